// [pkg/ebgbs_pkg.sv]
// Package for the external bus control and boot select block.
// Assumes one instruction clock and a core that issues one access at a time.
package ebgbs_pkg;
   // Data address map and program start addresses
   localparam logic [13:0] RAM_BASE      = 14'h3000;
   localparam logic [13:0] REG_BASE      = 14'h3800;
   localparam logic [13:0] PROG_START    = 14'h0000;
   localparam logic [13:0] ROM_START     = 14'h0800;
   // Register offsets
   localparam logic [13:0] OFS_SER_DIV   = 14'h3FF5;
   localparam logic [13:0] OFS_SER_CTL   = 14'h3FF6;
   localparam logic [13:0] OFS_SER_WEN   = 14'h3FFA;
   localparam logic [13:0] OFS_ROM_WAIT  = 14'h3FFE;
   localparam logic [13:0] OFS_SYS_CTL   = 14'h3FFF;
   // Wait-state field layout, three bits per zone
   localparam int          WAIT_W        = 3;
   localparam int          ZONE0_LSB     = 0;
   localparam int          ZONE1_LSB     = 3;
   localparam int          ZONE2_LSB     = 6;
   localparam int          ROM_EN_BIT    = 15;
   localparam int          RUN_GRANT_BIT = 4;
   localparam logic [15:0] ROM_WAIT_RST  = 16'h01FF;
   localparam logic [2:0]  PROG_WAIT     = 3'h7;
   // Access space and decoded region
   typedef enum logic [1:0] {SP_DATA, SP_PROG, SP_BOOT} ebgbs_space_t;
   typedef enum logic [2:0] {RG_ZONE0, RG_ZONE1, RG_ZONE2, RG_RAM, RG_REG,
                             RG_OTHER} ebgbs_region_t;
   typedef enum logic [1:0] {MD_EPROM, MD_HOST, MD_EXT, MD_ROM} ebgbs_mode_t;
   // Core access request
   typedef struct packed {
      logic         valid;
      ebgbs_space_t space;
      logic         write;
      logic [13:0]  addr;
      logic [23:0]  wdata;
   } ebgbs_req_t;
endpackage

// [verification/ebgbs_master_model.sv]
// External bus master and external memory, facing the bus pins.
// Assumes the design drives address, selects and strobes only while
// the bus output enable is high.
`timescale 1ns/1ps
`default_nettype none
module ebgbs_master_model (
   input  wire logic        clk_in,
   input  wire logic        want_in,
   input  wire logic [13:0] addr_in,
   input  wire logic [23:0] wdata_in,
   input  wire logic        oe_in,
   input  wire logic        dsel_n_in,
   input  wire logic        psel_n_in,
   input  wire logic        bsel_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        wr_n_in,
   input  wire logic        hang_n_in,
   output logic [23:0]      rdata_out,
   output logic             mreq_n_out,
   output logic             viol_out
);
   logic [23:0] mem [0:16383];
   logic [23:0] last_q;
   logic        gave_q;
   logic [1:0]  nsel;
   // ------------------------------------------
   // Memory
   // ------------------------------------------
   // Preset pattern: upper lines echo the address
   initial begin
      for (int i = 0; i < 16384; i++) begin
         mem[i] = {2'h0, i[13:0], 8'h5A};
      end
      last_q = 24'h000000;
      gave_q = 1'b0;
      mreq_n_out = 1'b1;
      viol_out = 1'b0;
   end
   // Released lines show the inverse of the last value, never a hold
   assign rdata_out = (oe_in && !rd_n_in) ? mem[addr_in] : ~last_q;
   assign nsel = 2'(!dsel_n_in) + 2'(!psel_n_in) + 2'(!bsel_n_in);
   // Store on strobe; flag any strobe without exactly one select
   always @(posedge clk_in) begin
      last_q <= rdata_out;
      if (oe_in && !wr_n_in) begin
         mem[addr_in] <= wdata_in;
      end
      if (oe_in && !(rd_n_in && wr_n_in) && nsel != 2'h1) begin
         viol_out <= 1'b1;
      end
   end
   // ------------------------------------------
   // Bus master
   // ------------------------------------------
   // Gives the bus back on hang and stays off until the want drops
   always @(negedge clk_in) begin
      gave_q <= want_in && (gave_q || hang_n_in === 1'b0);
      mreq_n_out <= !want_in || gave_q || hang_n_in === 1'b0;
   end
endmodule
`default_nettype wire

// [verification/ebgbs_top_bench.sv]
// Self-checking bench for the bus control and boot select block.
// Assumes the master model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module ebgbs_top_bench;
   logic        clk, rst_n, bm, mm, bdone, want, done, run, bload, bhost;
   logic        rom, edoe, boe, dsel_n, psel_n, bsel_n, rd_n, wr_n;
   logic        gnt_n, hang_n, viol, mreq_n;
   logic [13:0] start, eaddr;
   logic [23:0] rdata, edout, edin;
   logic [47:0] exp_q[$];
   logic [47:0] e;
   int          n_errors, n_tests, lat, l7;
   ebgbs_pkg::ebgbs_req_t req;
   // ------------------------------------------
   // Clock, design and partner
   // ------------------------------------------
   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ebgbs_top #(.RAM_WORDS(2048)) i_dut (
      .ref_clk_in(clk), .rst_n_in(rst_n), .boot_source_select_in(bm),
      .memory_map_select_in(mm), .bus_request_n_in(mreq_n),
      .boot_done_in(bdone), .core_req_in(req), .ext_data_in(edin),
      .core_done_out(done), .core_rdata_out(rdata), .core_run_out(run),
      .boot_load_out(bload), .boot_from_host_out(bhost),
      .start_addr_out(start), .rom_enable_out(rom), .ext_addr_out(eaddr),
      .ext_data_out(edout), .ext_data_oe_out(edoe), .bus_oe_out(boe),
      .data_mem_select_n_out(dsel_n), .prog_mem_select_n_out(psel_n),
      .boot_mem_select_n_out(bsel_n), .read_strobe_n_out(rd_n),
      .store_strobe_n_out(wr_n), .bus_grant_n_out(gnt_n),
      .grant_hang_n_out(hang_n));
   ebgbs_master_model i_mdl (
      .clk_in(clk), .want_in(want), .addr_in(eaddr), .wdata_in(edout),
      .oe_in(boe), .dsel_n_in(dsel_n), .psel_n_in(psel_n),
      .bsel_n_in(bsel_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
      .hang_n_in(hang_n), .rdata_out(edin), .mreq_n_out(mreq_n),
      .viol_out(viol));
   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic chk(input logic [23:0] g, input logic [23:0] x);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One core access; mask zero marks a write with nothing to compare
   task automatic acc(input logic [1:0] sp, input logic wr,
      input logic [13:0] a, input logic [23:0] d, input logic [23:0] m);
      exp_q.push_back({m, d & m});
      req <= '{1'b1, ebgbs_pkg::ebgbs_space_t'(sp), wr, a, d};
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (done !== 1'b1 && lat < 40);
      chk(24'(done), 24'h1);
      req.valid <= 1'b0;
      @(negedge clk);
   endtask
   // Bounded wait for the grant to reach a level
   task automatic wgr(input logic v);
      for (int i = 0; i < 10 && gnt_n !== v; i++) @(negedge clk);
      chk(24'(gnt_n), 24'(v));
   endtask
   task automatic boot(input logic b, input logic m);
      rst_n <= 1'b0;
      bm <= b;
      mm <= m;
      repeat (2) @(negedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
   endtask
   // ------------------------------------------
   // Checking and stimulus
   // ------------------------------------------
   // Oldest note meets each done pulse, looked at where it has settled
   always @(negedge clk) begin
      if (rst_n === 1'b1 && done === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(24'h0, 24'h1);
         end else begin
            e = exp_q.pop_front();
            chk(rdata & e[47:24], e[23:0]);
         end
      end
      // Write data must be driven for the whole store strobe
      if (rst_n === 1'b1 && wr_n === 1'b0) begin
         chk(24'(edoe), 24'h1);
      end
   end
   // Long enough for all scenarios several times over
   initial begin
      #2000000;
      n_errors++;
      summarize();
   end
   // Main sequence, all drives on the falling edge
   initial begin
      logic [23:0] d;
      logic [13:0] at [8];
      at = '{14'h0123, 14'h1123, 14'h2123, 14'h3000, 14'h37FF, 14'h3FF5,
             14'h3FF6, 14'h3FFA};
      rst_n = 1'b0;
      bm = 1'b0;
      mm = 1'b0;
      bdone = 1'b0;
      want = 1'b0;
      req = '0;
      n_errors = 0;
      n_tests = 0;
      void'($urandom(82));
      // Strap modes in turn: EPROM, host, ROM, external map last
      for (int k = 0; k < 4; k++) begin
         boot(k[0] ^ k[1], k[1]);
         chk(24'(bload), 24'(!mm));
         chk(24'(bhost), 24'(bm && !mm));
         chk(24'(start), (bm && mm) ? 24'h000800 : 24'h000000);
         chk(24'(rom), 24'(bm && mm));
         if (!mm) begin
            chk(24'(run), 24'h0);
            if (!bm) acc(2'h2, 1'b0, 14'h0105, 24'h05, 24'hFF);
            bdone <= 1'b1;
            @(negedge clk);
            bdone <= 1'b0;
            @(negedge clk);
         end
         chk(24'(run), 24'h1);
         acc(0, 0, 14'h3FFE, {8'h0, bm & mm, 15'h01FF}, 24'hFFFF);
      end
      acc(0, 1, 14'h3FFF, 24'h0, 0);
      // Zones, on-chip RAM ends and registers, each written then read
      foreach (at[i]) begin
         d = 24'($urandom & 32'hFFFF);
         acc(0, 1, at[i], d, 0);
         acc(0, 0, at[i], d, 24'hFFFF);
      end
      acc(0, 0, 14'h3800, 24'h0, 24'hFFFF);
      acc(0, 0, 14'h0200, 24'h0200, 24'hFFFF);
      // Program space keeps all 24 lines and its own select
      d = 24'($urandom);
      acc(1, 1, 14'h0300, d, 0);
      acc(1, 0, 14'h0300, d, 24'hFFFFFF);
      acc(0, 0, 14'h2004, 24'h2004, 24'hFFFF);
      l7 = lat;
      acc(0, 1, 14'h3FFE, 24'h003F, 0);
      acc(0, 0, 14'h2004, 24'h2004, 24'hFFFF);
      chk(24'(l7 - lat), 24'h7);
      want <= 1'b1;
      wgr(0);
      chk(24'(boe), 24'h0);
      chk(24'(run), 24'h0);
      want <= 1'b0;
      wgr(1);
      chk(24'(run), 24'h1);
      acc(0, 1, 14'h3FFF, 24'h0010, 0);
      want <= 1'b1;
      wgr(0);
      chk(24'(run), 24'h1);
      acc(0, 0, 14'h3800, 24'h0, 24'hFFFF);
      fork
         acc(0, 0, 14'h0040, 24'h0040, 24'hFFFF);
         begin
            for (int i = 0; i < 10 && hang_n !== 1'b0; i++) @(negedge clk);
            chk(24'(hang_n), 24'h0);
         end
      join
      chk(24'(hang_n), 24'h1);
      want <= 1'b0;
      wgr(1);
      // Request arriving in mid-access waits for its end
      fork
         acc(0, 0, 14'h1040, 24'h1040, 24'hFFFF);
         begin
            repeat (2) @(negedge clk);
            want <= 1'b1;
            while (rd_n === 1'b0) begin
               chk(24'(gnt_n), 24'h1);
               @(negedge clk);
            end
         end
      join
      wgr(0);
      want <= 1'b0;
      wgr(1);
      chk(24'(boe), 24'h1);
      rst_n <= 1'b0;
      want <= 1'b1;
      wgr(0);
      want <= 1'b0;
      wgr(1);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk(24'(viol), 24'h0);
      chk(24'(exp_q.size()), 24'h0);
      summarize();
   end
endmodule
`default_nettype wire

// [verilog/ebgbs_top.sv]
// External bus control, boot mode select and bus grant logic.
// Assumes straps are stable around reset release and the core holds a
// request until core_done_out pulses.
//
// Summary of operation
// - Host port boot when host strap, no map
// - No map, low boot strap: boot bytes from external memory
// - Both straps high: ROM on, start 0x0800
// - ROM enable reads one in stand-alone mode
// - Map high, boot low: start external 0x0000
// - After boot, start internal RAM 0x0000
// - 14-bit address, data on upper 16 lines
// - Data select with read or store strobe
// - 0x3000 window served by on-chip RAM
// - 0x3800 to 0x3FFF decode control registers
// - Three zones, each seven waits after reset
// - Idle request: float bus, grant, halt
// - Run mode halts only on external access
// - Grant waits until current access completes
// - Grant may fall between two accesses
// - Released request: drop grant, resume
// - Request handling live even during reset
// - Hang flag when access blocked by grant
// - Release: finish access, then drop hang
// - Registers reached by data memory accesses
// - Strobes only with exactly one select
// - No map: RAM at 0x0000, auto boot
`timescale 1ns/1ps
`default_nettype none
module ebgbs_top #(
   parameter int RAM_WORDS = 2048
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                boot_source_select_in,
   input  wire logic                memory_map_select_in,
   input  wire logic                bus_request_n_in,
   input  wire logic                boot_done_in,
   input  wire ebgbs_pkg::ebgbs_req_t core_req_in,
   input  wire logic [23:0]         ext_data_in,
   output logic                     core_done_out,
   output logic [23:0]              core_rdata_out,
   output logic                     core_run_out,
   output logic                     boot_load_out,
   output logic                     boot_from_host_out,
   output logic [13:0]              start_addr_out,
   output logic                     rom_enable_out,
   output logic [13:0]              ext_addr_out,
   output logic [23:0]              ext_data_out,
   output logic                     ext_data_oe_out,
   output logic                     bus_oe_out,
   output logic                     data_mem_select_n_out,
   output logic                     prog_mem_select_n_out,
   output logic                     boot_mem_select_n_out,
   output logic                     read_strobe_n_out,
   output logic                     store_strobe_n_out,
   output logic                     bus_grant_n_out,
   output logic                     grant_hang_n_out
);
   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   // Zones split the external 12K words in 4K steps
   function automatic ebgbs_pkg::ebgbs_region_t region_of(
      input ebgbs_pkg::ebgbs_space_t sp, input logic [13:0] a);
      if (sp != ebgbs_pkg::SP_DATA) return ebgbs_pkg::RG_OTHER;
      if (a >= ebgbs_pkg::REG_BASE) return ebgbs_pkg::RG_REG;
      if (a >= ebgbs_pkg::RAM_BASE) return ebgbs_pkg::RG_RAM;
      unique case (a[13:12])
         2'h0: return ebgbs_pkg::RG_ZONE0;
         2'h1: return ebgbs_pkg::RG_ZONE1;
         default: return ebgbs_pkg::RG_ZONE2;
      endcase
   endfunction
   ebgbs_pkg::ebgbs_region_t region;
   logic                     req_int;
   logic                     req_ext;
   assign region  = region_of(core_req_in.space, core_req_in.addr);
   assign req_int = core_req_in.valid &
                    (region == ebgbs_pkg::RG_RAM ||
                     region == ebgbs_pkg::RG_REG);
   assign req_ext = core_req_in.valid & ~req_int;

   // -------------------------------------------------------------
   // Straps and boot sequencing
   // -------------------------------------------------------------
   typedef enum logic [1:0] {BS_STRAP, BS_LOAD, BS_RUN} ebgbs_boot_t;
   ebgbs_boot_t          boot_q;
   ebgbs_pkg::ebgbs_mode_t mode_q;
   logic                 halt;
   // Straps caught on the first edge after release, never under reset
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_q         <= BS_STRAP;
         mode_q         <= ebgbs_pkg::MD_EPROM;
         start_addr_out <= ebgbs_pkg::PROG_START;
      end else begin
         unique case (boot_q)
            BS_STRAP: begin
               mode_q <= ebgbs_pkg::ebgbs_mode_t'({memory_map_select_in,
                                                   boot_source_select_in});
               if (memory_map_select_in) begin
                  boot_q <= BS_RUN;
                  start_addr_out <= boot_source_select_in ?
                     ebgbs_pkg::ROM_START : ebgbs_pkg::PROG_START;
               end else begin
                  boot_q <= BS_LOAD;
                  start_addr_out <= ebgbs_pkg::PROG_START;
               end
            end
            BS_LOAD: if (boot_done_in) begin
               boot_q <= BS_RUN;
            end
            BS_RUN: boot_q <= BS_RUN;
         endcase
      end
   end

   assign boot_load_out      = (boot_q == BS_LOAD);
   assign boot_from_host_out = (mode_q == ebgbs_pkg::MD_HOST);
   assign core_run_out       = (boot_q == BS_RUN) & ~halt;

   // -------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------
   logic [15:0] ser_div_q;
   logic [15:0] ser_ctl_q;
   logic [15:0] ser_wen_q;
   logic [15:0] rom_wait_q;
   logic [15:0] sys_ctl_q;
   logic        done_q;
   logic        reg_wr;
   assign reg_wr = core_req_in.valid & core_req_in.write &
                   (region == ebgbs_pkg::RG_REG);

   // Plain data-memory writes reach the registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ser_div_q  <= 16'h0000;
         ser_ctl_q  <= 16'h0000;
         ser_wen_q  <= 16'h0000;
         rom_wait_q <= ebgbs_pkg::ROM_WAIT_RST;
         sys_ctl_q  <= 16'h0000;
      end else begin
         if (boot_q == BS_STRAP) begin
            rom_wait_q[ebgbs_pkg::ROM_EN_BIT] <=
               memory_map_select_in & boot_source_select_in;
         end
         if (reg_wr && !done_q) begin
            unique case (core_req_in.addr)
               ebgbs_pkg::OFS_SER_DIV:  ser_div_q  <= core_req_in.wdata[15:0];
               ebgbs_pkg::OFS_SER_CTL:  ser_ctl_q  <= core_req_in.wdata[15:0];
               ebgbs_pkg::OFS_SER_WEN:  ser_wen_q  <= core_req_in.wdata[15:0];
               ebgbs_pkg::OFS_ROM_WAIT: rom_wait_q <= core_req_in.wdata[15:0];
               ebgbs_pkg::OFS_SYS_CTL:  sys_ctl_q  <= core_req_in.wdata[15:0];
               default: ;
            endcase
         end
      end
   end
   assign rom_enable_out = rom_wait_q[ebgbs_pkg::ROM_EN_BIT];

   // -------------------------------------------------------------
   // On-chip data RAM and internal read path
   // -------------------------------------------------------------
   logic [15:0] ram_q [RAM_WORDS];
   logic [15:0] int_rdata;
   logic        ram_wr;
   assign ram_wr = req_int & core_req_in.write &
                   (region == ebgbs_pkg::RG_RAM) & ~done_q;
   // Register read mux, unmapped control words read zero
   always_comb begin
      unique case (core_req_in.addr)
         ebgbs_pkg::OFS_SER_DIV:  int_rdata = ser_div_q;
         ebgbs_pkg::OFS_SER_CTL:  int_rdata = ser_ctl_q;
         ebgbs_pkg::OFS_SER_WEN:  int_rdata = ser_wen_q;
         ebgbs_pkg::OFS_ROM_WAIT: int_rdata = rom_wait_q;
         ebgbs_pkg::OFS_SYS_CTL:  int_rdata = sys_ctl_q;
         default: int_rdata = 16'h0000;
      endcase
      if (region == ebgbs_pkg::RG_RAM) begin
         int_rdata = ram_q[core_req_in.addr[10:0]];
      end
   end

   // RAM has no reset; contents are program data
   always_ff @(posedge ref_clk_in) begin
      if (ram_wr) begin
         ram_q[core_req_in.addr[10:0]] <= core_req_in.wdata[15:0];
      end
   end

   // -------------------------------------------------------------
   // Bus request synchroniser and grant
   // -------------------------------------------------------------
   // No reset here so that granting works while reset is held
   logic req_meta_q;
   logic req_sync_q;
   logic grant_q;
   logic ext_busy_q;
   logic ext_last;
   always_ff @(posedge ref_clk_in) begin
      req_meta_q <= ~bus_request_n_in;
      req_sync_q <= req_meta_q;
      grant_q    <= req_sync_q &
                    (grant_q | ~ext_busy_q | ext_last);
   end
   assign bus_grant_n_out = ~grant_q;
   assign halt = grant_q &
                 (~sys_ctl_q[ebgbs_pkg::RUN_GRANT_BIT] | req_ext);

   // -------------------------------------------------------------
   // External access sequencer
   // -------------------------------------------------------------
   logic [2:0]  wait_q;
   logic [2:0]  zone_wait;
   logic        start_ext;
   logic        hang_q;
   ebgbs_pkg::ebgbs_space_t sp_q;
   logic        wr_q;
   assign ext_last  = ext_busy_q & (wait_q == 3'h0);
   assign start_ext = req_ext & ~ext_busy_q & ~grant_q & ~req_sync_q &
                      ~done_q;
   always_comb begin
      unique case (region)
         ebgbs_pkg::RG_ZONE0: zone_wait =
            rom_wait_q[ebgbs_pkg::ZONE0_LSB +: ebgbs_pkg::WAIT_W];
         ebgbs_pkg::RG_ZONE1: zone_wait =
            rom_wait_q[ebgbs_pkg::ZONE1_LSB +: ebgbs_pkg::WAIT_W];
         ebgbs_pkg::RG_ZONE2: zone_wait =
            rom_wait_q[ebgbs_pkg::ZONE2_LSB +: ebgbs_pkg::WAIT_W];
         default: zone_wait = ebgbs_pkg::PROG_WAIT;
      endcase
   end

   // Access holds its strobe for wait count plus one cycles
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_busy_q   <= 1'b0;
         wait_q       <= 3'h0;
         sp_q         <= ebgbs_pkg::SP_DATA;
         wr_q         <= 1'b0;
         ext_addr_out <= 14'h0000;
         ext_data_out <= 24'h000000;
      end else if (start_ext) begin
         ext_busy_q   <= 1'b1;
         wait_q       <= zone_wait;
         sp_q         <= core_req_in.space;
         wr_q         <= core_req_in.write;
         ext_addr_out <= core_req_in.addr;
         ext_data_out <= (core_req_in.space == ebgbs_pkg::SP_PROG) ?
            core_req_in.wdata : {core_req_in.wdata[15:0], 8'h00};
      end else if (ext_last) begin
         ext_busy_q <= 1'b0;
      end else if (ext_busy_q) begin
         wait_q <= wait_q - 3'h1;
      end
   end

   // Completion and read data for both paths
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_q         <= 1'b0;
         core_rdata_out <= 24'h000000;
      end else begin
         done_q <= (req_int & ~done_q) | ext_last;
         if (req_int && !done_q) begin
            core_rdata_out <= {8'h00, int_rdata};
         end else if (ext_last) begin
            core_rdata_out <= (sp_q == ebgbs_pkg::SP_PROG) ? ext_data_in :
               (sp_q == ebgbs_pkg::SP_BOOT) ? {16'h0000, ext_data_in[15:8]} :
               {8'h00, ext_data_in[23:8]};
         end
      end
   end
   assign core_done_out = done_q;

   // Hang flag: setting wins over the clear at completion
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hang_q <= 1'b0;
      end else if (grant_q && req_ext && !ext_busy_q) begin
         hang_q <= 1'b1;
      end else if (ext_last) begin
         hang_q <= 1'b0;
      end
   end
   assign grant_hang_n_out = ~hang_q;

   // Pins float while granted; one select per access
   assign bus_oe_out            = ~grant_q;
   assign data_mem_select_n_out = ~(ext_busy_q & sp_q == ebgbs_pkg::SP_DATA);
   assign prog_mem_select_n_out = ~(ext_busy_q & sp_q == ebgbs_pkg::SP_PROG);
   assign boot_mem_select_n_out = ~(ext_busy_q & sp_q == ebgbs_pkg::SP_BOOT);
   assign read_strobe_n_out     = ~(ext_busy_q & ~wr_q);
   assign store_strobe_n_out    = ~(ext_busy_q & wr_q);
   assign ext_data_oe_out       = ext_busy_q & wr_q & ~grant_q;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   sequence s_ext_done;
      ext_busy_q ##0 (wait_q == 3'h0);
   endsequence
   a_grant_idle: assert property (@(posedge ref_clk_in)
      !ext_busy_q && req_sync_q && !grant_q
      |=> !bus_grant_n_out && !bus_oe_out)
      else $error("grant not given on idle bus");
   a_grant_waits: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) !bus_grant_n_out |-> !ext_busy_q)
      else $error("grant during external access");
   a_grant_drop: assert property (@(posedge ref_clk_in)
      grant_q && !req_sync_q |=> bus_grant_n_out && bus_oe_out)
      else $error("grant held after release");
   a_sync_delay: assert property (@(posedge ref_clk_in)
      !bus_grant_n_out && !$past(req_sync_q) |-> 1'b0)
      else $error("grant without synchronised request");
   a_one_select: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) !read_strobe_n_out || !store_strobe_n_out
      |-> $onehot({data_mem_select_n_out, prog_mem_select_n_out,
                   boot_mem_select_n_out} ^ 3'h7))
      else $error("strobe without a single select");
   a_wait_reset: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) boot_q == BS_STRAP
      |-> rom_wait_q[8:0] == 9'h1FF)
      else $error("zone wait not seven after reset");
   a_hang_clear: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) s_ext_done ##0 hang_q |=> grant_hang_n_out)
      else $error("hang not cleared after access");
   a_rom_start: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) boot_q == BS_STRAP && memory_map_select_in
      && boot_source_select_in |=> start_addr_out == ebgbs_pkg::ROM_START
      && rom_enable_out ##1 (boot_q == BS_RUN)[*2])
      else $error("stand-alone start wrong");
   a_run_halt: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in) grant_q && sys_ctl_q[ebgbs_pkg::RUN_GRANT_BIT]
      && !req_ext && boot_q == BS_RUN |-> core_run_out)
      else $error("halted in run mode without access");
endmodule
`default_nettype wire
